// [rtl/dcfpf_top.sv]
// FIFO core with write port, read port, status flags and offset access.
// Assumes one system clock; write and read "clock edges" arrive as one-cycle
// enable pulses, and all pins are synchronous to the system clock.
//
// Behaviour
// - Enabled write stores word when not full
// - Write enable high stores nothing
// - Writes ignored while full, both modes
// - Write-side flags change only on write edges
// - Full releases two write edges after read
// - Read-side flags change only on read edges
// - Enabled read loads next word when not empty
// - Read enable high holds output register, except fall-through prefetch into an empty register
// - Standard mode reads every word; empty blocks reads
// - Empty rises two read edges after write
// - Fall-through presents first word third read edge
// - Output-ready falls with first valid word
// - Output-ready rises only on true read
// - Serial bit shifts in when offset load and shift enable low
// - Shift enable high freezes offset registers in serial method
// - Output enable low drives bus, high floats
// - Load level at reset picks offset defaults
// - Load low accesses offsets; writes by selected method only, reads always parallel
// - Standard full after depth writes
// - Input-ready counts output register word too
// - Full flag through two register stages
// - Empty two stages, output-ready three stages
// - Mode pin at reset selects fall-through
// - Partial reset clears pointers, keeps settings
`timescale 1ns/1ns
module dcfpf_top
  import dcfpf_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int DEPTH = DEPTH_DEF
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic masterResetN,
  input wire logic partialResetN,
  input wire logic writeClkEn,
  input wire logic writeEnN,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic readClkEn,
  input wire logic readEnN,
  input wire logic outputEnN,
  input wire logic offsetLoadN,
  input wire logic serialShiftEnableN,
  input wire logic modeSerialIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOutOe,
  output logic fullInputReadyN,
  output logic emptyOutputReadyN,
  output logic almostFullN,
  output logic almostEmptyN,
  output logic halfFullN,
  output logic fallThroughMode
);

  localparam int ADDR_W = $clog2(DEPTH);
  localparam int PTR_W = ADDR_W + 1;
  localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);
  localparam logic [PTR_W-1:0] HALF_P = PTR_W'(DEPTH / 2);

  // Storage, one word per location
  logic [DATA_W-1:0] mem [DEPTH];

  logic fallThrough_q; // Mode caught at master reset
  logic serialLoad_q; // Offset load method caught at master reset
  logic clrPtrs; // Any reset that empties the buffer

  // Write side
  logic [PTR_W-1:0] wrPtr_q; // Binary write pointer, extra wrap bit
  logic [PTR_W-1:0] wrPtr_d; // Next write pointer
  logic [PTR_W-1:0] wrGray_q; // Registered gray copy for the crossing
  logic [PTR_W-1:0] rdSyncBin; // Read pointer as seen by the write side
  logic [PTR_W-1:0] wrCount; // Words held, write-side view
  logic [PTR_W-1:0] wrCountAfter; // Words held after this edge
  logic memFull; // RAM array has no free location
  logic fifoWrite; // Word is stored this cycle
  logic almostFull_q; // Registered almost-full, active low

  // Read side
  logic [PTR_W-1:0] rdPtr_q; // Binary read pointer
  logic [PTR_W-1:0] rdPtr_d; // Next read pointer
  logic [PTR_W-1:0] rdGray_q; // Registered gray copy for the crossing
  logic [PTR_W-1:0] wrSyncBin; // Write pointer as seen by the read side
  logic [PTR_W-1:0] rdCount; // Words held, read-side view
  logic [PTR_W-1:0] rdCountAfter; // Words held after this edge
  logic memEmpty; // RAM array holds nothing
  logic loadWord; // Word moves into the output register
  logic dropLast; // True read of the last presented word
  logic offRead; // Offset read onto the output register
  logic outValid_q; // Fall-through: output register holds a word
  logic [DATA_W-1:0] dataOut_q; // Output register
  logic almostEmpty_q; // Registered almost-empty, active low
  logic halfFull_q; // Half-full, active low

  // Offsets
  logic [ADDR_W-1:0] emptyOffset;
  logic [ADDR_W-1:0] fullOffset;
  logic [ADDR_W-1:0] offsetWord;

  assign clrPtrs = reset | ~masterResetN | ~partialResetN;

  // Mode and method straps; held through partial reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fallThrough_q <= 1'b0;
      serialLoad_q <= 1'b0;
    end else if (~masterResetN) begin
      fallThrough_q <= modeSerialIn;
      serialLoad_q <= offsetLoadN;
    end
  end

  assign fallThroughMode = fallThrough_q;

  // Write-side arithmetic; wrap is free because the pointer is modulo 2*DEPTH
  assign wrCount = wrPtr_q - rdSyncBin;
  assign memFull = (wrCount == DEPTH_P);
  // Offset load low turns write enable into an offset write in the parallel method, not a FIFO write
  assign fifoWrite = writeClkEn & ~writeEnN & offsetLoadN & ~memFull;
  assign wrPtr_d = wrPtr_q + PTR_W'(fifoWrite);
  assign wrCountAfter = wrPtr_d - rdSyncBin;

  // Write pointer and its gray image
  always_ff @(posedge sys_clk) begin
    if (clrPtrs) begin
      wrPtr_q <= '0;
      wrGray_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      wrGray_q <= wrPtr_d ^ (wrPtr_d >> 1);
    end
  end

  // RAM write; no reset so the array maps onto block memory
  always_ff @(posedge sys_clk) begin
    if (fifoWrite) begin
      mem[wrPtr_q[ADDR_W-1:0]] <= dataIn;
    end
  end

  // Read pointer enters the write side through two registers stepped by write edges
  dcfpf_ptr_sync #(
    .W(PTR_W)
  ) u_rd_to_wr (
    .sys_clk(sys_clk),
    .clear(clrPtrs),
    .sampleEn(writeClkEn),
    .grayIn(rdGray_q),
    .binOut(rdSyncBin)
  );

  // Full is low when full; input-ready is high when full. Both come only
  // from write-side registers, so a stopped write side freezes them.
  // In fall-through the prefetched word has left the array, so one extra
  // write fits before input-ready goes high.
  assign fullInputReadyN = fallThrough_q ? memFull : ~memFull;

  // Almost-full, write edges only
  always_ff @(posedge sys_clk) begin
    if (clrPtrs) begin
      almostFull_q <= 1'b1;
    end else if (writeClkEn) begin
      almostFull_q <= ~(wrCountAfter >= (DEPTH_P - PTR_W'(fullOffset)));
    end
  end

  assign almostFullN = almostFull_q;

  // Read-side arithmetic
  assign rdCount = wrSyncBin - rdPtr_q;
  assign memEmpty = (rdCount == '0);

  // Standard: each word needs a read enable. Fall-through: an empty output
  // register pulls the next word on its own.
  always_comb begin
    loadWord = 1'b0;
    if (readClkEn && offsetLoadN && !memEmpty) begin
      if (fallThrough_q) begin
        loadWord = ~outValid_q | ~readEnN;
      end else begin
        loadWord = ~readEnN;
      end
    end
  end

  // Last presented word consumed with nothing behind it
  assign dropLast = readClkEn & offsetLoadN & fallThrough_q & outValid_q & ~readEnN
                    & memEmpty;
  // Offsets are read in parallel through the output register
  assign offRead = readClkEn & ~offsetLoadN & ~readEnN;
  assign rdPtr_d = rdPtr_q + PTR_W'(loadWord);
  assign rdCountAfter = wrSyncBin - rdPtr_d;

  // Read pointer and its gray image
  always_ff @(posedge sys_clk) begin
    if (clrPtrs) begin
      rdPtr_q <= '0;
      rdGray_q <= '0;
    end else begin
      rdPtr_q <= rdPtr_d;
      rdGray_q <= rdPtr_d ^ (rdPtr_d >> 1);
    end
  end

  // Write pointer enters the read side through two registers stepped by read edges
  dcfpf_ptr_sync #(
    .W(PTR_W)
  ) u_wr_to_rd (
    .sys_clk(sys_clk),
    .clear(clrPtrs),
    .sampleEn(readClkEn),
    .grayIn(wrGray_q),
    .binOut(wrSyncBin)
  );

  // Output register; holds its word unless a load or offset read happens
  always_ff @(posedge sys_clk) begin
    if (clrPtrs) begin
      dataOut_q <= '0;
    end else if (loadWord) begin
      dataOut_q <= mem[rdPtr_q[ADDR_W-1:0]];
    end else if (offRead) begin
      dataOut_q <= DATA_W'(offsetWord);
    end
    // Otherwise hold: read enable high keeps the previous word
  end

  // Fall-through valid flag; the last word stays on the pins after it drops
  always_ff @(posedge sys_clk) begin
    if (clrPtrs) begin
      outValid_q <= 1'b0;
    end else if (loadWord && fallThrough_q) begin
      outValid_q <= 1'b1;
    end else if (dropLast) begin
      outValid_q <= 1'b0;
    end
  end

  // Empty: two sync stages then combinational compare.
  // Output-ready: the sync stages plus the valid register, a third stage,
  // so it falls in the same cycle the word appears.
  assign emptyOutputReadyN = fallThrough_q ? ~outValid_q : ~memEmpty;

  // Almost-empty, read edges only; fall-through counts the presented word
  always_ff @(posedge sys_clk) begin
    if (clrPtrs) begin
      almostEmpty_q <= 1'b0;
    end else if (readClkEn) begin
      almostEmpty_q <= ~(rdCountAfter <= (PTR_W'(emptyOffset) + PTR_W'(fallThrough_q)));
    end
  end

  assign almostEmptyN = almostEmpty_q;

  // Half-full: write edges may only set it low, read edges may only return it high.
  // Setting wins when both edges land together so a fill is never missed.
  always_ff @(posedge sys_clk) begin
    if (clrPtrs) begin
      halfFull_q <= 1'b1;
    end else if (writeClkEn && (wrCountAfter > HALF_P)) begin
      halfFull_q <= 1'b0;
    end else if (readClkEn && (rdCountAfter <= HALF_P)) begin
      halfFull_q <= 1'b1;
    end
  end

  assign halfFullN = halfFull_q;

  // Offset registers; serial data shares the mode pin after reset
  dcfpf_offset_regs #(
    .W(ADDR_W)
  ) u_offsets (
    .sys_clk(sys_clk),
    .reset(reset),
    .masterResetN(masterResetN),
    .serialLoad(serialLoad_q),
    .offsetLoadN(offsetLoadN),
    .writeClkEn(writeClkEn),
    .writeEnN(writeEnN),
    .serialShiftEnableN(serialShiftEnableN),
    .serialIn(modeSerialIn),
    .parallelIn(dataIn[ADDR_W-1:0]),
    .readClkEn(readClkEn),
    .readEnN(readEnN),
    .emptyOffset(emptyOffset),
    .fullOffset(fullOffset),
    .readWord(offsetWord)
  );

  // Bus drive: the pad works out high impedance from the enable
  assign dataOut = dataOut_q;
  assign dataOutOe = ~outputEnN;

endmodule : dcfpf_top

// [shared/dcfpf_pkg.sv]
// Shared constants for the dual-clock FIFO with port flags.
// Assumes every design file imports the whole package in its header.
package dcfpf_pkg;

  // Data word width
  localparam int DATA_W_DEF = 18;
  // Words in the RAM array, smaller variant
  localparam int DEPTH_DEF = 8192;
  // Offset default when offset load is low at master reset (127 words)
  localparam logic [15:0] OFS_DEF_PAR = 16'h007f;
  // Offset default when offset load is high at master reset (1,023 words)
  localparam logic [15:0] OFS_DEF_SER = 16'h03ff;
  // Synchroniser depth for pointer crossing
  localparam int SYNC_STAGES = 2;

endpackage : dcfpf_pkg

// [rtl/dcfpf_ptr_sync.sv]
// Two-stage gray pointer synchroniser, stepped by the receiving side's edge pulse.
// Assumes the gray input is registered in the sending side and changes one bit per step.
`timescale 1ns/1ns
module dcfpf_ptr_sync
  import dcfpf_pkg::*;
#(
  parameter int W = 14
) (
  input wire logic sys_clk,
  input wire logic clear,
  input wire logic sampleEn,
  input wire logic [W-1:0] grayIn,
  output logic [W-1:0] binOut
);

  logic [W-1:0] stage1_q; // First stage, read only by stage2_q
  logic [W-1:0] stage2_q; // Settled gray value

  // Both stages step only on the receiving edge, so a stopped side freezes them
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else if (sampleEn) begin
      stage1_q <= grayIn;
      stage2_q <= stage1_q;
    end
  end

  // Gray to binary on the settled stage
  always_comb begin
    binOut[W-1] = stage2_q[W-1];
    for (int i = W - 2; i >= 0; i--) begin
      binOut[i] = binOut[i+1] ^ stage2_q[i];
    end
  end

endmodule : dcfpf_ptr_sync

// [rtl/dcfpf_offset_regs.sv]
// Almost-empty and almost-full offset registers with serial or parallel load.
// Assumes the top gives edge pulses for both sides and the captured load method.
`timescale 1ns/1ns
module dcfpf_offset_regs
  import dcfpf_pkg::*;
#(
  parameter int W = 13
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic masterResetN,
  input wire logic serialLoad,
  input wire logic offsetLoadN,
  input wire logic writeClkEn,
  input wire logic writeEnN,
  input wire logic serialShiftEnableN,
  input wire logic serialIn,
  input wire logic [W-1:0] parallelIn,
  input wire logic readClkEn,
  input wire logic readEnN,
  output logic [W-1:0] emptyOffset,
  output logic [W-1:0] fullOffset,
  output logic [W-1:0] readWord
);

  logic [W-1:0] emptyOfs_q; // Almost-empty offset
  logic [W-1:0] fullOfs_q; // Almost-full offset
  logic wrSel_q; // Parallel write target: 0 empty, 1 full
  logic rdSel_q; // Parallel read target: 0 empty, 1 full
  logic parWrite; // Parallel write this edge
  logic serShift; // Serial shift this edge

  assign parWrite = writeClkEn & ~offsetLoadN & ~serialLoad & ~writeEnN;
  assign serShift = writeClkEn & ~offsetLoadN & serialLoad & ~serialShiftEnableN;

  // Offset values; a high shift enable stops serial shifts, parallel writes land only in the parallel method
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      emptyOfs_q <= W'(OFS_DEF_SER);
      fullOfs_q <= W'(OFS_DEF_SER);
    end else if (~masterResetN) begin
      // Load level at reset picks the default pair
      emptyOfs_q <= offsetLoadN ? W'(OFS_DEF_SER) : W'(OFS_DEF_PAR);
      fullOfs_q <= offsetLoadN ? W'(OFS_DEF_SER) : W'(OFS_DEF_PAR);
    end else if (serShift) begin
      // Bits enter at the top of the full offset and walk down into empty
      {fullOfs_q, emptyOfs_q} <= {serialIn, fullOfs_q, emptyOfs_q[W-1:1]};
    end else if (parWrite) begin
      if (wrSel_q) begin
        fullOfs_q <= parallelIn;
      end else begin
        emptyOfs_q <= parallelIn;
      end
    end
  end

  // Parallel write pointer restarts whenever load is released
  always_ff @(posedge sys_clk) begin
    if (reset || ~masterResetN || offsetLoadN) begin
      wrSel_q <= 1'b0;
    end else if (parWrite) begin
      wrSel_q <= ~wrSel_q;
    end
  end

  // Parallel read pointer, always allowed whatever the load method
  always_ff @(posedge sys_clk) begin
    if (reset || ~masterResetN || offsetLoadN) begin
      rdSel_q <= 1'b0;
    end else if (readClkEn && ~readEnN) begin
      rdSel_q <= ~rdSel_q;
    end
  end

  assign emptyOffset = emptyOfs_q;
  assign fullOffset = fullOfs_q;
  assign readWord = rdSel_q ? fullOfs_q : emptyOfs_q;

endmodule : dcfpf_offset_regs

// [tb/dcfpf_top_properties.sv]
// Port checker for the FIFO top, bound into every dcfpf_top instance.
// Assumes one clock and the synchronous reset as disable.
`timescale 1ns/1ns
module dcfpf_top_properties
  import dcfpf_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int DEPTH = DEPTH_DEF
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic masterResetN,
  input wire logic partialResetN,
  input wire logic writeClkEn,
  input wire logic writeEnN,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic readClkEn,
  input wire logic readEnN,
  input wire logic outputEnN,
  input wire logic offsetLoadN,
  input wire logic serialShiftEnableN,
  input wire logic modeSerialIn,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic dataOutOe,
  input wire logic fullInputReadyN,
  input wire logic emptyOutputReadyN,
  input wire logic almostFullN,
  input wire logic almostEmptyN,
  input wire logic halfFullN,
  input wire logic fallThroughMode
);
  default clocking dcb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // No FIFO reset pending this cycle
  logic quiet;
  assign quiet = masterResetN && partialResetN;
  // True read or true write this cycle
  logic rdTrue;
  logic wrTrue;
  assign rdTrue = readClkEn && !readEnN;
  assign wrTrue = writeClkEn && !writeEnN;

  AST_OE: assert property (dataOutOe == !outputEnN)
    else $error("output enable wrong");
  AST_WR_FLAGS: assert property (quiet && !writeClkEn |=> $stable(fullInputReadyN)
    && $stable(almostFullN)) else $error("write flags moved without write edge");
  AST_RD_FLAGS: assert property (quiet && !readClkEn |=> $stable(emptyOutputReadyN)
    && $stable(almostEmptyN)) else $error("read flags moved without read edge");
  AST_HF_DOWN: assert property (quiet && !writeClkEn |=> !$fell(halfFullN))
    else $error("half full set without write edge");
  AST_HF_UP: assert property (quiet && !readClkEn |=> !$rose(halfFullN))
    else $error("half full cleared without read edge");
  AST_HOLD: assert property (quiet && offsetLoadN && !fallThroughMode && !rdTrue
    |=> $stable(dataOut)) else $error("output changed without read");
  AST_OR_RISE: assert property (quiet && fallThroughMode && !emptyOutputReadyN
    && !rdTrue |=> !emptyOutputReadyN) else $error("ready rose without true read");
  AST_FULL_SET: assert property (quiet && !fallThroughMode && fullInputReadyN
    && !wrTrue |=> fullInputReadyN) else $error("full without write");
  AST_MODE: assert property (!masterResetN |=> fallThroughMode == $past(modeSerialIn))
    else $error("mode not captured");
  AST_MODE_KEEP: assert property (masterResetN |=> $stable(fallThroughMode))
    else $error("mode changed outside master reset");
  AST_PRS: assert property (masterResetN && !partialResetN |=> dataOut == '0
    && emptyOutputReadyN == fallThroughMode && fullInputReadyN == !fallThroughMode)
    else $error("partial reset state wrong");
endmodule : dcfpf_top_properties

bind dcfpf_top dcfpf_top_properties #(.DATA_W(DATA_W), .DEPTH(DEPTH)) u_props (
  .sys_clk(sys_clk), .reset(reset), .masterResetN(masterResetN),
  .partialResetN(partialResetN), .writeClkEn(writeClkEn), .writeEnN(writeEnN),
  .dataIn(dataIn), .readClkEn(readClkEn), .readEnN(readEnN), .outputEnN(outputEnN),
  .offsetLoadN(offsetLoadN), .serialShiftEnableN(serialShiftEnableN),
  .modeSerialIn(modeSerialIn), .dataOut(dataOut), .dataOutOe(dataOutOe),
  .fullInputReadyN(fullInputReadyN), .emptyOutputReadyN(emptyOutputReadyN),
  .almostFullN(almostFullN), .almostEmptyN(almostEmptyN), .halfFullN(halfFullN),
  .fallThroughMode(fallThroughMode));

// [tb/dcfpf_partner.sv]
// Producer and consumer model: write and read clock edges with their enables.
// Assumes the bench calls put and get; drives on the falling edge.
`timescale 1ns/1ns
module dcfpf_partner (
  input wire logic sys_clk,
  output logic writeClkEn,
  output logic writeEnN,
  output logic [17:0] dataIn,
  output logic readClkEn,
  output logic readEnN
);
  // Idle: no edges, data shows a pattern so stale words never match
  initial begin
    writeClkEn = 1'b0;
    writeEnN = 1'b1;
    dataIn = 18'h2aaaa;
    readClkEn = 1'b0;
    readEnN = 1'b1;
  end
  // One write edge; data inverted after release
  task put(input logic en, input logic [17:0] d);
    @(negedge sys_clk);
    writeClkEn = 1'b1;
    writeEnN = ~en;
    dataIn = d;
    @(negedge sys_clk);
    writeClkEn = 1'b0;
    writeEnN = 1'b1;
    dataIn = ~d;
  endtask : put
  // One read edge; en asks for a word
  task get(input logic en);
    @(negedge sys_clk);
    readClkEn = 1'b1;
    readEnN = ~en;
    @(negedge sys_clk);
    readClkEn = 1'b0;
    readEnN = 1'b1;
  endtask : get
endmodule : dcfpf_partner

// [tb/dcfpf_top_bench.sv]
// Self-checking bench for the FIFO top, small depth for short fills.
// Assumes the partner model supplies write and read edges.
`timescale 1ns/1ns
module dcfpf_top_bench;
  import dcfpf_pkg::*;
  localparam int DEP = 1024;
  logic sys_clk, reset, masterResetN, partialResetN, outputEnN, offsetLoadN;
  logic serialShiftEnableN, modeSerialIn, writeClkEn, writeEnN, readClkEn, readEnN;
  logic [17:0] dataIn, dataOut;
  logic dataOutOe, fullInputReadyN, emptyOutputReadyN, almostFullN, almostEmptyN;
  logic halfFullN, fallThroughMode;
  logic [19:0] pat = 20'h5a5c3;
  int error_cnt = 0;
  int checks = 0;

  dcfpf_top #(.DEPTH(DEP)) dut (.sys_clk(sys_clk), .reset(reset),
    .masterResetN(masterResetN), .partialResetN(partialResetN), .writeClkEn(writeClkEn),
    .writeEnN(writeEnN), .dataIn(dataIn), .readClkEn(readClkEn), .readEnN(readEnN),
    .outputEnN(outputEnN), .offsetLoadN(offsetLoadN), .serialShiftEnableN(serialShiftEnableN),
    .modeSerialIn(modeSerialIn), .dataOut(dataOut), .dataOutOe(dataOutOe),
    .fullInputReadyN(fullInputReadyN), .emptyOutputReadyN(emptyOutputReadyN),
    .almostFullN(almostFullN), .almostEmptyN(almostEmptyN), .halfFullN(halfFullN),
    .fallThroughMode(fallThroughMode));
  dcfpf_partner u_pp (.sys_clk(sys_clk), .writeClkEn(writeClkEn), .writeEnN(writeEnN),
    .dataIn(dataIn), .readClkEn(readClkEn), .readEnN(readEnN));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Compare and count
  task chk(input logic [17:0] got, input logic [17:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // Master reset with mode and load method levels
  task mrst(input logic mode, input logic ld);
    @(negedge sys_clk);
    masterResetN = 1'b0;
    modeSerialIn = mode;
    offsetLoadN = ld;
    @(negedge sys_clk);
    masterResetN = 1'b1;
    modeSerialIn = 1'b0;
    offsetLoadN = 1'b1;
  endtask : mrst
  // Restart offset alternation, then open offset access
  task ldcyc;
    offsetLoadN = 1'b1;
    @(negedge sys_clk);
    offsetLoadN = 1'b0;
  endtask : ldcyc
  task final_report;
    $display("error_cnt %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // Watchdog: the run needs about 6,300 cycles, this allows 20,000
  initial begin
    #1000000;
    error_cnt++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    masterResetN = 1'b1;
    partialResetN = 1'b1;
    outputEnN = 1'b0;
    offsetLoadN = 1'b1;
    serialShiftEnableN = 1'b1;
    modeSerialIn = 1'b0;
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    // Standard mode: latency, empty, full, order
    mrst(1'b0, 1'b0);
    chk(emptyOutputReadyN, 0, "empty at reset");
    chk(fullInputReadyN, 1, "full at reset");
    u_pp.put(1'b1, 18'h1234a);
    u_pp.get(1'b0);
    chk(emptyOutputReadyN, 0, "empty early");
    u_pp.get(1'b0);
    chk(emptyOutputReadyN, 1, "empty late");
    u_pp.get(1'b1);
    chk(dataOut, 18'h1234a, "first word");
    u_pp.get(1'b1);
    chk(dataOut, 18'h1234a, "read while empty");
    chk(emptyOutputReadyN, 0, "empty after last");
    outputEnN = 1'b1;
    @(negedge sys_clk);
    chk(dataOutOe, 0, "bus floats");
    outputEnN = 1'b0;
    for (int i = 0; i < DEP; i++) u_pp.put(1'b1, 18'h00100 + 18'(i));
    chk(fullInputReadyN, 0, "full after depth");
    chk(halfFullN, 0, "half full after fill");
    chk(almostFullN, 0, "almost full after fill");
    u_pp.put(1'b1, 18'h3ffff);
    u_pp.get(1'b0);
    u_pp.get(1'b0);
    u_pp.get(1'b1);
    chk(dataOut, 18'h00100, "oldest word");
    chk(almostEmptyN, 1, "not almost empty when full");
    u_pp.put(1'b0, 18'h0);
    chk(fullInputReadyN, 0, "full release early");
    u_pp.put(1'b0, 18'h0);
    chk(fullInputReadyN, 1, "full release");
    for (int i = 1; i < DEP; i++) begin
      u_pp.get(1'b1);
      chk(dataOut, 18'h00100 + 18'(i), "drain order");
    end
    u_pp.get(1'b1);
    chk(dataOut, 18'h004ff, "no overflow word");
    chk(halfFullN, 1, "half full cleared by reads");
    chk(almostEmptyN, 0, "almost empty after drain");
    chk(almostFullN, 0, "almost full frozen without write edges");
    // Parallel offsets
    offsetLoadN = 1'b0;
    u_pp.get(1'b1);
    chk(dataOut, 18'h0007f, "empty offset default");
    u_pp.get(1'b1);
    chk(dataOut, 18'h0007f, "full offset default");
    ldcyc();
    u_pp.put(1'b1, 18'h00015);
    u_pp.put(1'b1, 18'h002a3);
    ldcyc();
    u_pp.get(1'b1);
    chk(dataOut, 18'h00015, "parallel empty offset");
    u_pp.get(1'b1);
    chk(dataOut, 18'h002a3, "parallel full offset");
    // Serial offsets
    mrst(1'b0, 1'b1);
    offsetLoadN = 1'b0;
    u_pp.get(1'b1);
    chk(dataOut, 18'h003ff, "serial default");
    u_pp.get(1'b1);
    chk(dataOut, 18'h003ff, "serial default full");
    ldcyc();
    serialShiftEnableN = 1'b0;
    for (int i = 0; i < 20; i++) begin
      modeSerialIn = pat[i];
      u_pp.put(1'b0, 18'h0);
    end
    serialShiftEnableN = 1'b1;
    modeSerialIn = 1'b1;
    u_pp.put(1'b0, 18'h0);
    u_pp.put(1'b1, 18'h00001);
    ldcyc();
    u_pp.get(1'b1);
    chk(dataOut, 18'h001c3, "serial empty offset");
    u_pp.get(1'b1);
    chk(dataOut, 18'h00169, "serial full offset");
    offsetLoadN = 1'b1;
    // Fall-through mode
    mrst(1'b1, 1'b1);
    chk(emptyOutputReadyN, 1, "ready at reset");
    chk(fullInputReadyN, 0, "input ready at reset");
    u_pp.put(1'b1, 18'h0beef);
    u_pp.get(1'b0);
    u_pp.get(1'b0);
    chk(emptyOutputReadyN, 1, "ready too early");
    u_pp.get(1'b0);
    chk(emptyOutputReadyN, 0, "ready with word");
    chk(dataOut, 18'h0beef, "fall through word");
    u_pp.get(1'b1);
    chk(emptyOutputReadyN, 1, "ready after last read");
    chk(dataOut, 18'h0beef, "last word stays");
    @(negedge sys_clk);
    partialResetN = 1'b0;
    @(negedge sys_clk);
    partialResetN = 1'b1;
    chk(dataOut, 18'h0, "partial reset clears");
    chk(fallThroughMode, 1, "mode kept");
    u_pp.put(1'b1, 18'h20000);
    repeat (3) u_pp.get(1'b0);
    chk(dataOut, 18'h20000, "prefetch after partial");
    for (int i = 1; i < DEP; i++) u_pp.put(1'b1, 18'(i));
    chk(fullInputReadyN, 0, "space left");
    u_pp.put(1'b1, 18'h00777);
    chk(fullInputReadyN, 1, "input ready after depth plus one");
    chk(halfFullN, 0, "half full in fall-through");
    chk(almostFullN, 0, "almost full in fall-through");
    final_report();
  end
endmodule : dcfpf_top_bench
